// ### logic/hfp_top.sv
// Purpose: host access to the rx/tx status and data queues
// Assumes: one-cycle rd/wr strobes, read data one cycle later
// Notes: in 16-bit mode the high half (addr[1]=1) completes a word
//
// Contract
// - writes to read-only locations change nothing
// - reads of write-only locations return zero
// - writing one clears bit, zero leaves it
// - clear-on-read bits clear when read
// - latched bits hold until register read
// - immune fields survive soft reset
// - reserved addresses: arbitrary reads, no host writes
// - every reset loads fixed default values; soft reset skips immune fields
// - four queues: rx status, rx data, tx status, tx data
// - rx status, rx data and tx data capacities set by configuration; tx status fixed at full depth
// - rx status pop read removes oldest
// - rx status view read keeps queue intact
// - every rx data read consumes the word; in 16-bit mode only the high-half (addr[1]=1) read does
// - rx data at eight aliases 00h-1Ch
// - all rx data aliases pop shared queue
// - tx status pop read removes oldest
// - tx status view read keeps queue intact
// - tx data at eight aliases 20h-3Ch
// - all tx data aliases push shared queue
`timescale 1ns/1ps
module hfp_top (
  input wire logic clock, // 200 MHz
  input wire logic rst, // system and power-on reset
  input wire logic soft_rst, // software reset
  input wire logic bus16_mode, // 1: 16-bit host bus
  input wire logic host_cs, // chip select
  input wire logic host_rd, // read strobe
  input wire logic host_wr, // write strobe
  input wire logic [7:0] host_addr, // byte address
  input wire logic [31:0] host_wdata, // write data
  output logic [31:0] host_rdata, // read data, registered
  output logic host_rd_ack, // read data valid
  input wire logic [4:0] rxs_limit, // rx status capacity
  input wire logic [4:0] rxd_limit, // rx data capacity
  input wire logic [4:0] txd_limit, // tx data capacity
  input wire logic rx_stat_valid, // mac rx status in
  output logic rx_stat_ready, // queue has room
  input wire logic [31:0] rx_stat_data, // rx status word
  input wire logic rx_data_valid, // mac rx data in
  output logic rx_data_ready, // queue has room
  input wire logic [31:0] rx_data_data, // rx data word
  input wire logic tx_stat_valid, // mac tx status in
  output logic tx_stat_ready, // queue has room
  input wire logic [31:0] tx_stat_data, // tx status word
  output logic tx_out_valid, // tx data to mac
  input wire logic tx_out_ready, // mac takes word
  output logic [31:0] tx_out_data // tx data word
);
  localparam int NQ = hfp_pkg::NQ;
  localparam int CW = hfp_pkg::CNT_W;

  logic any_rst;
  logic rd_go, wr_go, last_half;
  logic hit_rxd, hit_txd;
  logic [7:0] word_addr;
  logic [NQ-1:0] q_push, q_pop, q_full, q_empty, q_flush;
  logic [31:0] q_wdata [NQ];
  logic [31:0] q_head [NQ];
  logic [CW-1:0] q_cnt [NQ];
  logic [CW-1:0] q_lim [NQ];
  logic [15:0] tx_lo_reg;
  logic [hfp_pkg::ERR_W-1:0] err_reg, err_ev;
  logic [2:0] latch_reg;
  logic [hfp_pkg::KEEP_W-1:0] keep_reg;
  logic [31:0] rd_word, rd_next;
  logic [1:0] buf_cnt_reg;
  logic [31:0] buf0_reg, buf1_reg;
  logic buf_in, buf_out;
  default clocking @(posedge clock); endclocking
  default disable iff (any_rst);

  assign any_rst = rst | soft_rst;
  assign rd_go = host_cs & host_rd;
  assign wr_go = host_cs & host_wr;
  assign last_half = ~bus16_mode | host_addr[1];
  assign word_addr = {host_addr[7:2], 2'b00};
  assign hit_rxd = host_addr[7:5] == hfp_pkg::RXD_WIN;
  assign hit_txd = host_addr[7:5] == hfp_pkg::TXD_WIN;

  // zero or oversize limit means full depth
  function automatic logic [CW-1:0] clamp(input logic [CW-1:0] l);
    clamp = (l == '0 || l > hfp_pkg::DEPTH_CNT) ? hfp_pkg::DEPTH_CNT : l;
  endfunction : clamp

  assign q_lim[hfp_pkg::Q_RXS] = clamp(rxs_limit);
  assign q_lim[hfp_pkg::Q_RXD] = clamp(rxd_limit);
  assign q_lim[hfp_pkg::Q_TXS] = hfp_pkg::DEPTH_CNT;
  assign q_lim[hfp_pkg::Q_TXD] = clamp(txd_limit);

  // mac side pushes
  assign rx_stat_ready = ~q_full[hfp_pkg::Q_RXS];
  assign rx_data_ready = ~q_full[hfp_pkg::Q_RXD];
  assign tx_stat_ready = ~q_full[hfp_pkg::Q_TXS];
  assign q_push[hfp_pkg::Q_RXS] = rx_stat_valid & rx_stat_ready;
  assign q_push[hfp_pkg::Q_RXD] = rx_data_valid & rx_data_ready;
  assign q_push[hfp_pkg::Q_TXS] = tx_stat_valid & tx_stat_ready;
  assign q_wdata[hfp_pkg::Q_RXS] = rx_stat_data;
  assign q_wdata[hfp_pkg::Q_RXD] = rx_data_data;
  assign q_wdata[hfp_pkg::Q_TXS] = tx_stat_data;

  // any tx alias pushes the one queue; 16-bit pairs low then high
  assign q_push[hfp_pkg::Q_TXD] = wr_go & hit_txd & last_half
                                  & ~q_full[hfp_pkg::Q_TXD];
  assign q_wdata[hfp_pkg::Q_TXD] = bus16_mode ?
    {host_wdata[15:0], tx_lo_reg} : host_wdata;

  always_ff @(posedge clock) begin
    if (any_rst) begin
      tx_lo_reg <= 16'h0000;
    end else if (wr_go & hit_txd & bus16_mode & ~host_addr[1]) begin
      tx_lo_reg <= host_wdata[15:0];
    end
  end

  // host pops only on reads, never on writes
  assign q_pop[hfp_pkg::Q_RXS] = rd_go & last_half
    & (word_addr == hfp_pkg::RXS_POP_OFF)
    & ~q_empty[hfp_pkg::Q_RXS];
  assign q_pop[hfp_pkg::Q_RXD] = rd_go & hit_rxd & last_half
    & ~q_empty[hfp_pkg::Q_RXD];
  assign q_pop[hfp_pkg::Q_TXS] = rd_go & last_half
    & (word_addr == hfp_pkg::TXS_POP_OFF)
    & ~q_empty[hfp_pkg::Q_TXS];
  assign buf_in = ~q_empty[hfp_pkg::Q_TXD] & (buf_cnt_reg != 2'h2);
  assign q_pop[hfp_pkg::Q_TXD] = buf_in;

  assign q_flush[hfp_pkg::Q_RXS] = 1'b0;
  assign q_flush[hfp_pkg::Q_RXD] = wr_go
    & (word_addr == hfp_pkg::FLUSH_OFF)
    & host_wdata[hfp_pkg::FLUSH_RXD_BIT];
  assign q_flush[hfp_pkg::Q_TXS] = 1'b0;
  assign q_flush[hfp_pkg::Q_TXD] = 1'b0;

  // one circular queue per channel
  for (genvar q = 0; q < NQ; q++) begin : g_q
    logic [31:0] mem [hfp_pkg::DEPTH];
    logic [hfp_pkg::PTR_W-1:0] wp_reg, rp_reg;
    logic [CW-1:0] cnt_reg;

    always_ff @(posedge clock) begin
      if (q_push[q]) begin
        mem[wp_reg] <= q_wdata[q];
      end
    end

    always_ff @(posedge clock) begin
      if (any_rst) begin
        wp_reg <= '0;
        rp_reg <= '0;
        cnt_reg <= '0;
      end else if (q_flush[q]) begin
        rp_reg <= wp_reg;
        cnt_reg <= '0;
      end else begin
        if (q_push[q]) begin
          wp_reg <= wp_reg + 1'b1;
        end
        if (q_pop[q]) begin
          rp_reg <= rp_reg + 1'b1;
        end
        cnt_reg <= cnt_reg + CW'(q_push[q]) - CW'(q_pop[q]);
      end
    end

    assign q_head[q] = mem[rp_reg];
    assign q_cnt[q] = cnt_reg;
    assign q_full[q] = cnt_reg >= q_lim[q];
    assign q_empty[q] = cnt_reg == '0;
  end

  // two-entry buffer toward the mac; stall backs up the tx queue
  assign buf_out = tx_out_valid & tx_out_ready;
  assign tx_out_valid = buf_cnt_reg != 2'h0;
  assign tx_out_data = buf0_reg;

  always_ff @(posedge clock) begin
    if (any_rst) begin
      buf_cnt_reg <= 2'h0;
      buf0_reg <= hfp_pkg::RD_ZERO;
      buf1_reg <= hfp_pkg::RD_ZERO;
    end else begin
      unique case ({buf_in, buf_out})
        2'b10: begin
          if (buf_cnt_reg == 2'h0) buf0_reg <= q_head[hfp_pkg::Q_TXD];
          else buf1_reg <= q_head[hfp_pkg::Q_TXD];
          buf_cnt_reg <= buf_cnt_reg + 2'h1;
        end
        2'b01: begin
          buf0_reg <= buf1_reg;
          buf_cnt_reg <= buf_cnt_reg - 2'h1;
        end
        2'b11: begin
          if (buf_cnt_reg == 2'h1) begin
            buf0_reg <= q_head[hfp_pkg::Q_TXD];
          end else begin
            buf0_reg <= buf1_reg;
            buf1_reg <= q_head[hfp_pkg::Q_TXD];
          end
        end
        2'b00: ;
      endcase
    end
  end

  // sticky errors; a new event beats a same-cycle clear
  assign err_ev[hfp_pkg::ERR_TXD_OVR] = wr_go & hit_txd & last_half
    & q_full[hfp_pkg::Q_TXD];
  assign err_ev[hfp_pkg::ERR_RXD_UNR] = rd_go & hit_rxd & last_half
    & q_empty[hfp_pkg::Q_RXD];
  assign err_ev[hfp_pkg::ERR_RXS_UNR] = rd_go & q_empty[hfp_pkg::Q_RXS]
    & (word_addr == hfp_pkg::RXS_POP_OFF
       || word_addr == hfp_pkg::RXS_VIEW_OFF);
  assign err_ev[hfp_pkg::ERR_TXS_UNR] = rd_go & q_empty[hfp_pkg::Q_TXS]
    & (word_addr == hfp_pkg::TXS_POP_OFF
       || word_addr == hfp_pkg::TXS_VIEW_OFF);

  always_ff @(posedge clock) begin
    if (any_rst) begin
      err_reg <= hfp_pkg::ERR_RST;
    end else if (wr_go && word_addr == hfp_pkg::ERR_OFF) begin
      err_reg <= (err_reg & ~host_wdata[hfp_pkg::ERR_W-1:0])
                 | err_ev;
    end else begin
      err_reg <= err_reg | err_ev;
    end
  end

  // latch_high_bit, latch_low_bit and a clear-on-read bit;
  // a read re-arms each latch from the live condition
  logic latch_rd;
  assign latch_rd = rd_go & last_half & (word_addr == hfp_pkg::LATCH_OFF);

  always_ff @(posedge clock) begin
    if (any_rst) begin
      latch_reg <= hfp_pkg::LATCH_RST;
    end else begin
      latch_reg[hfp_pkg::LAT_RXD_FULL] <= q_full[hfp_pkg::Q_RXD]
        | (latch_reg[hfp_pkg::LAT_RXD_FULL] & ~latch_rd);
      latch_reg[hfp_pkg::LAT_TXD_ROOM] <= ~q_full[hfp_pkg::Q_TXD]
        & (latch_reg[hfp_pkg::LAT_TXD_ROOM] | latch_rd);
      latch_reg[hfp_pkg::LAT_TXS_NEW] <= q_push[hfp_pkg::Q_TXS]
        | (latch_reg[hfp_pkg::LAT_TXS_NEW] & ~latch_rd);
    end
  end

  // soft_reset_immune field: host writes and the system reset change it, soft reset does not
  always_ff @(posedge clock) begin
    if (rst) begin
      keep_reg <= hfp_pkg::KEEP_RST;
    end else if (wr_go && word_addr == hfp_pkg::KEEP_OFF) begin
      keep_reg <= host_wdata[hfp_pkg::KEEP_W-1:0];
    end
  end

  // read mux; read-only words have no write path at all
  always_comb begin
    rd_word = hfp_pkg::RD_ZERO;
    if (hit_rxd) begin
      rd_word = q_empty[hfp_pkg::Q_RXD] ? hfp_pkg::RD_ZERO
                : q_head[hfp_pkg::Q_RXD];
    end else if (hit_txd) begin
      rd_word = hfp_pkg::RD_ZERO;
    end else begin
      unique case (word_addr)
        hfp_pkg::RXS_POP_OFF, hfp_pkg::RXS_VIEW_OFF:
          rd_word = q_empty[hfp_pkg::Q_RXS] ? hfp_pkg::RD_ZERO
                    : q_head[hfp_pkg::Q_RXS];
        hfp_pkg::TXS_POP_OFF, hfp_pkg::TXS_VIEW_OFF:
          rd_word = q_empty[hfp_pkg::Q_TXS] ? hfp_pkg::RD_ZERO
                    : q_head[hfp_pkg::Q_TXS];
        hfp_pkg::LEVEL_OFF:
          rd_word = {3'h0, q_cnt[hfp_pkg::Q_TXD], 3'h0,
                     q_cnt[hfp_pkg::Q_TXS], 3'h0,
                     q_cnt[hfp_pkg::Q_RXD], 3'h0,
                     q_cnt[hfp_pkg::Q_RXS]};
        hfp_pkg::ERR_OFF: rd_word = {28'h0, err_reg};
        hfp_pkg::LATCH_OFF: rd_word = {29'h0, latch_reg};
        hfp_pkg::KEEP_OFF: rd_word = {16'h0, keep_reg};
        default: rd_word = hfp_pkg::RD_ZERO;
      endcase
    end
    if (bus16_mode) begin
      rd_next = host_addr[1] ? {16'h0, rd_word[31:16]}
                : {16'h0, rd_word[15:0]};
    end else begin
      rd_next = rd_word;
    end
  end

  always_ff @(posedge clock) begin
    if (any_rst) begin
      host_rdata <= hfp_pkg::RD_ZERO;
      host_rd_ack <= 1'b0;
    end else begin
      host_rd_ack <= rd_go;
      if (rd_go) begin
        host_rdata <= rd_next;
      end
    end
  end

  sequence rxs_view_s;
    rd_go && !host_wr && !bus16_mode
      && word_addr == hfp_pkg::RXS_VIEW_OFF;
  endsequence
  sequence rxd_read_s;
    rd_go && hit_rxd && last_half && !q_empty[hfp_pkg::Q_RXD];
  endsequence

  rxd_pop_a: assert property (
    rxd_read_s and (!q_push[hfp_pkg::Q_RXD] && !q_flush[hfp_pkg::Q_RXD])
    |=> q_cnt[hfp_pkg::Q_RXD] == $past(q_cnt[hfp_pkg::Q_RXD]) - 5'h1)
    else $error("rx data read did not consume a word");

  rxs_view_a: assert property (
    rxs_view_s and !q_push[hfp_pkg::Q_RXS]
    |=> $stable(q_cnt[hfp_pkg::Q_RXS]) && host_rd_ack)
    else $error("rx status view changed the queue");

  rxs_pop_a: assert property (
    rd_go && !bus16_mode && word_addr == hfp_pkg::RXS_POP_OFF
    && !q_empty[hfp_pkg::Q_RXS]
    |=> host_rdata == $past(q_head[hfp_pkg::Q_RXS]))
    else $error("rx status pop returned wrong word");

  txs_pop_a: assert property (
    rd_go && last_half && word_addr == hfp_pkg::TXS_POP_OFF
    && !q_empty[hfp_pkg::Q_TXS] && !q_push[hfp_pkg::Q_TXS]
    |=> q_cnt[hfp_pkg::Q_TXS] == $past(q_cnt[hfp_pkg::Q_TXS]) - 5'h1)
    else $error("tx status pop did not remove entry");

  wo_zero_a: assert property (
    rd_go && (hit_txd || word_addr == hfp_pkg::FLUSH_OFF)
    |=> host_rd_ack && host_rdata == hfp_pkg::RD_ZERO)
    else $error("write-only location read nonzero");

  txd_push_a: assert property (
    wr_go && hit_txd && last_half && !q_full[hfp_pkg::Q_TXD]
    && !buf_in |=> q_cnt[hfp_pkg::Q_TXD]
    == $past(q_cnt[hfp_pkg::Q_TXD]) + 5'h1)
    else $error("tx data alias write not queued");

  w1c_a: assert property (
    wr_go && word_addr == hfp_pkg::ERR_OFF && host_wdata[0]
    && !err_ev[0] |=> !err_reg[0])
    else $error("write one did not clear error bit");

  latch_hold_a: assert property (
    latch_reg[hfp_pkg::LAT_RXD_FULL] && !latch_rd
    |=> latch_reg[hfp_pkg::LAT_RXD_FULL])
    else $error("latched bit dropped without read");

  keep_soft_a: assert property (disable iff (rst)
    soft_rst |=> keep_reg == $past(keep_reg))
    else $error("immune field changed by soft reset");

  ro_write_a: assert property (
    wr_go && (hit_rxd || word_addr == hfp_pkg::RXS_POP_OFF)
    && !rx_data_valid && !rx_stat_valid
    |=> $stable(q_cnt[hfp_pkg::Q_RXD]) && $stable(q_cnt[hfp_pkg::Q_RXS]))
    else $error("write to read port changed a queue");

endmodule : hfp_top

// ### logic/hfp_pkg.sv
// Purpose: shared constants for the host queue port block
// Assumes: byte addresses on the host bus, one aligned word each
// Notes: queue depth fixed, capacity trimmed by limit inputs
package hfp_pkg;
  localparam int DW = 32;
  localparam int DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam int NQ = 4;
  // queue indices
  localparam int Q_RXS = 0;
  localparam int Q_RXD = 1;
  localparam int Q_TXS = 2;
  localparam int Q_TXD = 3;
  localparam logic [CNT_W-1:0] DEPTH_CNT = 5'h10;
  // data windows: eight aliases each, decoded by addr[7:5]
  localparam logic [2:0] RXD_WIN = 3'h0;
  localparam logic [2:0] TXD_WIN = 3'h1;
  localparam logic [7:0] RXD_BASE = 8'h00;
  localparam logic [7:0] TXD_BASE = 8'h20;
  // status ports and side registers
  localparam logic [7:0] RXS_POP_OFF = 8'h40;
  localparam logic [7:0] RXS_VIEW_OFF = 8'h44;
  localparam logic [7:0] TXS_POP_OFF = 8'h48;
  localparam logic [7:0] TXS_VIEW_OFF = 8'h4c;
  localparam logic [7:0] LEVEL_OFF = 8'h50;
  localparam logic [7:0] ERR_OFF = 8'h54;
  localparam logic [7:0] LATCH_OFF = 8'h58;
  localparam logic [7:0] KEEP_OFF = 8'h5c;
  localparam logic [7:0] FLUSH_OFF = 8'h60;
  // error bits, write-one-to-clear
  localparam int ERR_W = 4;
  localparam int ERR_TXD_OVR = 0;
  localparam int ERR_RXD_UNR = 1;
  localparam int ERR_RXS_UNR = 2;
  localparam int ERR_TXS_UNR = 3;
  // latch register bits
  localparam int LAT_RXD_FULL = 0;
  localparam int LAT_TXD_ROOM = 1;
  localparam int LAT_TXS_NEW = 2;
  localparam int KEEP_W = 16;
  localparam int FLUSH_RXD_BIT = 0;
  // values after reset
  localparam logic [ERR_W-1:0] ERR_RST = 4'h0;
  localparam logic [2:0] LATCH_RST = 3'h2;
  localparam logic [KEEP_W-1:0] KEEP_RST = 16'h0000;
  localparam logic [DW-1:0] RD_ZERO = 32'h0000_0000;
endpackage : hfp_pkg

// ### bench/hfp_mac_model.sv
// Purpose: mac-side partner, pushes status and data, sinks tx data
// Assumes: ready is sampled at the falling edge, words move on rising
// Notes: idle data shows the inverse of the last word until a push on another channel inverts it again
`timescale 1ns/1ps
module hfp_mac_model (
  input wire logic clock, // bench clock
  input wire logic stall, // 1: refuse tx data words
  output logic rx_stat_valid, // rx status offer
  input wire logic rx_stat_ready, // rx status room
  output logic [31:0] rx_stat_data, // rx status word
  output logic rx_data_valid, // rx data offer
  input wire logic rx_data_ready, // rx data room
  output logic [31:0] rx_data_data, // rx data word
  output logic tx_stat_valid, // tx status offer
  input wire logic tx_stat_ready, // tx status room
  output logic [31:0] tx_stat_data, // tx status word
  input wire logic tx_out_valid, // tx data offered
  output logic tx_out_ready, // tx data taken
  input wire logic [31:0] tx_out_data // tx data word
);
  logic [31:0] got[$];

  initial begin
    rx_stat_valid = 1'b0;
    rx_data_valid = 1'b0;
    tx_stat_valid = 1'b0;
    rx_stat_data = 32'h0000_0000;
    rx_data_data = 32'h0000_0000;
    tx_stat_data = 32'h0000_0000;
    tx_out_ready = 1'b0;
  end

  // channel 0 rx status, 1 rx data, 2 tx status
  task automatic push(input int ch, input logic [31:0] d);
    @(negedge clock);
    case (ch)
      0: begin
        rx_stat_valid = 1'b1;
        rx_stat_data = d;
        while (rx_stat_ready !== 1'b1) @(negedge clock);
      end
      1: begin
        rx_data_valid = 1'b1;
        rx_data_data = d;
        while (rx_data_ready !== 1'b1) @(negedge clock);
      end
      default: begin
        tx_stat_valid = 1'b1;
        tx_stat_data = d;
        while (tx_stat_ready !== 1'b1) @(negedge clock);
      end
    endcase
    @(negedge clock);
    rx_stat_valid = 1'b0;
    rx_data_valid = 1'b0;
    tx_stat_valid = 1'b0;
    rx_stat_data = ~rx_stat_data;
    rx_data_data = ~rx_data_data;
    tx_stat_data = ~tx_stat_data;
  endtask : push

  always @(negedge clock) begin
    tx_out_ready <= !stall;
  end

  always @(posedge clock) begin
    if (tx_out_valid === 1'b1 && tx_out_ready === 1'b1) begin
      got.push_back(tx_out_data);
    end
  end
endmodule : hfp_mac_model

// ### bench/host_fifo_port_access_tb_top.sv
// Purpose: directed host-bus checks of the queue port block
// Assumes: strobes driven on falling edges, ack awaited under a bound
// Notes: 16-bit compares look at bits 15:0 only
`timescale 1ns/1ps
module host_fifo_port_access_tb_top;
  logic clock, rst, soft_rst, bus16_mode, host_cs, host_rd, host_wr;
  logic [7:0] host_addr;
  logic [31:0] host_wdata, host_rdata, rxsd, rxdd, txsd, txod, d;
  logic host_rd_ack, rxsv, rxsr, rxdv, rxdr, txsv, txsr, txov, txor, stall;
  logic [4:0] rxs_limit, rxd_limit, txd_limit;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;

  hfp_top hfp_top_i (.clock(clock), .rst(rst), .soft_rst(soft_rst),
    .bus16_mode(bus16_mode), .host_cs(host_cs), .host_rd(host_rd),
    .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rd_ack(host_rd_ack),
    .rxs_limit(rxs_limit), .rxd_limit(rxd_limit), .txd_limit(txd_limit),
    .rx_stat_valid(rxsv), .rx_stat_ready(rxsr), .rx_stat_data(rxsd),
    .rx_data_valid(rxdv), .rx_data_ready(rxdr), .rx_data_data(rxdd),
    .tx_stat_valid(txsv), .tx_stat_ready(txsr), .tx_stat_data(txsd),
    .tx_out_valid(txov), .tx_out_ready(txor), .tx_out_data(txod));

  hfp_mac_model hfp_mac_model_i (.clock(clock), .stall(stall),
    .rx_stat_valid(rxsv), .rx_stat_ready(rxsr), .rx_stat_data(rxsd),
    .rx_data_valid(rxdv), .rx_data_ready(rxdr), .rx_data_data(rxdd),
    .tx_stat_valid(txsv), .tx_stat_ready(txsr), .tx_stat_data(txsd),
    .tx_out_valid(txov), .tx_out_ready(txor), .tx_out_data(txod));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  // a hang counts as a mismatch
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge clock);
    host_cs = 1'b1;
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = v;
    @(negedge clock);
    host_cs = 1'b0;
    host_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    int n;
    @(negedge clock);
    host_cs = 1'b1;
    host_rd = 1'b1;
    host_addr = a;
    @(negedge clock);
    host_cs = 1'b0;
    host_rd = 1'b0;
    n = 0;
    while (host_rd_ack !== 1'b1 && n < 4) begin
      @(negedge clock);
      n++;
    end
    if (n == 4) begin
      err_total++;
      $display("unexpected at %0t: no read answer", $time);
    end
    v = host_rdata;
    if (bus16_mode) v = {16'h0000, v[15:0]};
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a, d);
    chk(d, exp);
  endtask : rdc

  task automatic wait_got(input int n);
    int k;
    k = 0;
    while (hfp_mac_model_i.got.size() < n && k < 100) begin
      @(negedge clock);
      k++;
    end
    if (k == 100) begin
      err_total++;
      $display("unexpected at %0t: tx words missing", $time);
    end
  endtask : wait_got

  initial begin
    {rst, soft_rst, bus16_mode, host_cs, host_rd, host_wr} = 6'h20;
    {host_addr, host_wdata, stall} = 41'h0;
    rxs_limit = 5'h10;
    rxd_limit = 5'h08;
    txd_limit = 5'h10;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    chk({30'h0, rxsr, txsr}, 32'h3);
    rdc(8'h54, 32'h0);
    rdc(8'h5c, 32'h0);
    rdc(8'h50, 32'h0);
    rdc(8'h64, 32'h0);
    hfp_mac_model_i.push(0, 32'ha000_0001);
    hfp_mac_model_i.push(0, 32'ha000_0002);
    wr(8'h40, 32'hffff_ffff);
    rdc(8'h44, 32'ha000_0001);
    rdc(8'h44, 32'ha000_0001);
    rdc(8'h40, 32'ha000_0001);
    rdc(8'h40, 32'ha000_0002);
    rdc(8'h40, 32'h0);
    for (int i = 0; i < 8; i++) begin
      hfp_mac_model_i.push(1, 32'hb000_0000 + i);
    end
    @(negedge clock);
    chk({31'h0, rxdr}, 32'h0);
    rdc(8'h50, 32'h0000_0800);
    wr(8'h04, 32'hffff_ffff);
    for (int i = 0; i < 8; i++) rdc(8'(4 * i), 32'hb000_0000 + i);
    rdc(8'h1c, 32'h0);
    rdc(8'h58, 32'h3);
    rdc(8'h58, 32'h2);
    rdc(8'h54, 32'h6);
    wr(8'h54, 32'h2);
    rdc(8'h54, 32'h4);
    wr(8'h54, 32'h0);
    rdc(8'h54, 32'h4);
    wr(8'h50, 32'hffff_ffff);
    rdc(8'h50, 32'h0);
    wr(8'h54, 32'h4);
    rdc(8'h54, 32'h0);
    hfp_mac_model_i.push(1, 32'hb000_0009);
    rdc(8'h50, 32'h0000_0100);
    wr(8'h60, 32'h0000_0001);
    rdc(8'h50, 32'h0);
    hfp_mac_model_i.push(2, 32'hc000_0007);
    rdc(8'h58, 32'h6);
    rdc(8'h58, 32'h2);
    rdc(8'h4c, 32'hc000_0007);
    rdc(8'h4c, 32'hc000_0007);
    rdc(8'h48, 32'hc000_0007);
    rdc(8'h50, 32'h0);
    // stalled sink: buffer holds two, queue trimmed to six, ninth drops
    stall = 1'b1;
    txd_limit = 5'h06;
    for (int i = 0; i < 8; i++) begin
      wr(8'(8'h20 + 4 * i), 32'hd000_0000 + i);
    end
    wr(8'h3c, 32'hee00_0000);
    rdc(8'h50, 32'h0600_0000);
    rdc(8'h24, 32'h0);
    stall = 1'b0;
    wait_got(8);
    chk(32'(hfp_mac_model_i.got.size()), 32'h8);
    for (int i = 0; i < 8; i++) begin
      chk(hfp_mac_model_i.got[i], 32'hd000_0000 + i);
    end
    rdc(8'h54, 32'h1);
    wr(8'h54, 32'h1);
    rdc(8'h54, 32'h0);
    wr(8'h5c, 32'h0000_a5a5);
    @(negedge clock);
    soft_rst = 1'b1;
    @(negedge clock);
    soft_rst = 1'b0;
    rdc(8'h5c, 32'h0000_a5a5);
    @(negedge clock);
    rst = 1'b1;
    @(negedge clock);
    rst = 1'b0;
    rdc(8'h5c, 32'h0);
    bus16_mode = 1'b1;
    hfp_mac_model_i.push(1, 32'h1234_5678);
    rdc(8'h08, 32'h5678);
    rdc(8'h08, 32'h5678);
    rdc(8'h0a, 32'h1234);
    rdc(8'h50, 32'h0);
    wr(8'h20, 32'hbeef);
    wr(8'h3e, 32'hdead);
    wait_got(9);
    chk(hfp_mac_model_i.got[8], 32'hdead_beef);
    print_verdict();
  end
endmodule : host_fifo_port_access_tb_top
